// [verilog/sdram_cmd_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cmd_regs.vh"

module sdram_cmd_decode (
  // Clock and reset
  input wire REF_CLK,
  input wire RSTN,
  // AXI4-Lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Memory command bus
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire CKE,
  input wire [1:0] BA,
  input wire [12:0] ADDR,
  input wire [7:0] BYTE_DATA_MASK,
  // Data lines
  input wire [63:0] DQ_IN,
  output reg [63:0] DQ_OUT,
  output wire [7:0] DQ_OE
);

  // Column of beat cnt for a given start, length code and type
  function [9:0] beat_col;
    input [9:0] start;
    input [9:0] cnt;
    input [2:0] bl;
    input inter;
    reg [9:0] msk;
    reg [9:0] off;
    begin
      case (bl)
        `BL_2: msk = 10'h001;
        `BL_4: msk = 10'h003;
        `BL_8: msk = 10'h007;
        `BL_FULL: msk = 10'h3ff;
        default: msk = 10'h000;
      endcase
      // Type selects order; full page stays sequential
      if (inter && bl != `BL_FULL)
        off = (start & msk) ^ cnt;
      else
        off = start + cnt;
      beat_col = (start & ~msk) | (off & msk);
    end
  endfunction

  reg [11:0] mode_q;
  reg ctrl_en_q;
  reg [1:0] flags_q;
  reg [3:0] open_q;
  reg self_q;
  reg [15:0] ref_cnt_q;
  reg [12:0] ref_row_q;
  reg bst_act_q;
  reg bst_rd_q;
  reg bst_ap_q;
  reg [1:0] bst_bank_q;
  reg [2:0] bst_len_q;
  reg [9:0] bst_start_q;
  reg [9:0] bst_cnt_q;
  reg p1_v_q;
  reg [9:0] p1_col_q;
  reg drive_q;
  reg [7:0] m1_q;
  reg [7:0] m2_q;
  reg [63:0] mem [0:1023];
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [2:0] bl_code = mode_q[`MODE_BL_MSB:`MODE_BL_LSB];
  wire inter = mode_q[`MODE_TYPE_BIT];
  wire [2:0] cl_code = mode_q[`MODE_CL_MSB:`MODE_CL_LSB];
  wire [1:0] op_code = mode_q[`MODE_OP_MSB:`MODE_OP_LSB];
  // Write burst mode forces length one
  wire [2:0] wr_len = mode_q[`MODE_WBM_BIT] ? `BL_1 : bl_code;

  // Chip select gates decode; self refresh ignores commands
  wire sel = ~CS_N & ctrl_en_q & ~self_q;
  wire cmd_act = sel & ~RAS_N & CAS_N & WE_N;
  wire cmd_rd = sel & RAS_N & ~CAS_N & WE_N;
  wire cmd_wr = sel & RAS_N & ~CAS_N & ~WE_N;
  wire cmd_bst = sel & RAS_N & CAS_N & ~WE_N;
  wire cmd_pre = sel & ~RAS_N & CAS_N & ~WE_N;
  wire cmd_ref = sel & ~RAS_N & ~CAS_N & WE_N;
  wire cmd_lmr = sel & ~RAS_N & ~CAS_N & ~WE_N;

  wire [9:0] cur_col = beat_col(bst_start_q, bst_cnt_q, bst_len_q, inter);
  // Full page never ends on its own, only by terminate, precharge or a new read or write command
  wire last = (bst_len_q != `BL_FULL) &&
    (bst_cnt_q == beat_col(10'h000, 10'h3ff, bst_len_q, 1'b0));
  wire rd_beat = bst_act_q & bst_rd_q;
  wire cl3 = (cl_code == `CL_3);
  wire src_v = cl3 ? p1_v_q : rd_beat;
  wire [9:0] src_col = cl3 ? p1_col_q : cur_col;

  // Reads: mask sampled two edges back floats the byte
  assign DQ_OE = {8{drive_q}} & ~m2_q;

  // Writes: mask acts on the same edge
  wire wr_now = cmd_wr | (bst_act_q & ~bst_rd_q & ~cmd_rd);
  wire [9:0] wr_col = cmd_wr ? ADDR[9:0] : cur_col;
  integer i;
  always @(posedge REF_CLK) begin
    if (wr_now) begin
      for (i = 0; i < 8; i = i + 1) begin
        if (!BYTE_DATA_MASK[i])
          mem[wr_col][i*8 +: 8] <= DQ_IN[i*8 +: 8];
      end
    end
  end

  // Burst engine
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bst_act_q <= 1'b0;
      bst_rd_q <= 1'b0;
      bst_ap_q <= 1'b0;
      bst_bank_q <= 2'h0;
      bst_len_q <= 3'h0;
      bst_start_q <= 10'h000;
      bst_cnt_q <= 10'h000;
    end else if (cmd_rd) begin
      bst_act_q <= 1'b1;
      bst_rd_q <= 1'b1;
      bst_ap_q <= ADDR[`AUTO_PRE_BIT];
      bst_bank_q <= BA;
      bst_len_q <= bl_code;
      bst_start_q <= ADDR[9:0];
      bst_cnt_q <= 10'h000;
    end else if (cmd_wr) begin
      // Length one ends after the command beat
      bst_act_q <= (wr_len != `BL_1);
      bst_rd_q <= 1'b0;
      bst_ap_q <= ADDR[`AUTO_PRE_BIT];
      bst_bank_q <= BA;
      bst_len_q <= wr_len;
      bst_start_q <= ADDR[9:0];
      bst_cnt_q <= 10'h001;
    end else if (cmd_bst | cmd_pre) begin
      bst_act_q <= 1'b0;
    end else if (bst_act_q) begin
      bst_act_q <= ~last;
      bst_cnt_q <= bst_cnt_q + 10'h001;
    end
  end

  // Read pipeline and mask delay
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p1_v_q <= 1'b0;
      p1_col_q <= 10'h000;
      drive_q <= 1'b0;
      DQ_OUT <= 64'h0;
      m1_q <= 8'h00;
      m2_q <= 8'h00;
    end else begin
      p1_v_q <= rd_beat;
      p1_col_q <= cur_col;
      // Loaded at edge n+m-1, stable by n+m
      drive_q <= src_v;
      if (src_v)
        DQ_OUT <= mem[src_col];
      m1_q <= BYTE_DATA_MASK;
      m2_q <= m1_q;
    end
  end

  // Register write strobes, declared ahead of the refresh counter that reads them
  wire do_wr = aw_got_q & w_got_q & ~S_AXI_BVALID;
  wire ctrl_wr = do_wr & (aw_addr_q == `OFS_CONTROL) & w_strb_q[0];
  wire flag_wr = do_wr & (aw_addr_q == `OFS_FLAGS) & w_strb_q[0];

  // Banks, mode, refresh
  wire ap_close = bst_act_q & last & bst_ap_q & ~cmd_rd & ~cmd_wr & ~cmd_bst;
  wire wr1_close = cmd_wr & (wr_len == `BL_1) & ADDR[`AUTO_PRE_BIT];
  wire bad_mode = (op_code != 2'h0);
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      open_q <= 4'h0;
      mode_q <= `MODE_RESET;
      self_q <= 1'b0;
      ref_cnt_q <= 16'h0000;
      ref_row_q <= 13'h0000;
    end else begin
      if (cmd_act)
        open_q[BA] <= 1'b1;
      if (cmd_pre && ADDR[`AUTO_PRE_BIT])
        open_q <= 4'h0;
      else if (cmd_pre)
        open_q[BA] <= 1'b0;
      // Auto precharge at end of burst
      if (ap_close)
        open_q[bst_bank_q] <= 1'b0;
      if (wr1_close)
        open_q[BA] <= 1'b0;
      if (cmd_lmr)
        mode_q <= ADDR[11:0];
      // CKE picks auto or self refresh
      if (cmd_ref && CKE) begin
        ref_cnt_q <= ref_cnt_q + 16'h0001;
        ref_row_q <= ref_row_q + 13'h0001;
      end else if (ctrl_wr && w_data_q[`CTRL_CLR_BIT]) begin
        ref_cnt_q <= 16'h0000;
      end
      if (cmd_ref && !CKE)
        self_q <= 1'b1;
      else if (self_q && CKE)
        self_q <= 1'b0;
    end
  end

  // AXI4-Lite slave: one write and one read at a time
  assign S_AXI_AWREADY = ~aw_got_q & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_got_q & ~S_AXI_BVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
      ctrl_en_q <= `CTRL_RESET;
      flags_q <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        case (aw_addr_q)
          `OFS_MODE, `OFS_STATUS, `OFS_REFRESH, `OFS_CONTROL, `OFS_FLAGS:
            S_AXI_BRESP <= `RESP_OKAY;
          default: S_AXI_BRESP <= `RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (ctrl_wr)
        ctrl_en_q <= w_data_q[`CTRL_EN_BIT];
      // Set wins over a write-one clear in the same cycle
      // Reserved op mode, length or latency
      flags_q[`FLAG_BADMODE_BIT] <= (cmd_lmr && (ADDR[8:7] != 2'h0 ||
        (ADDR[2:0] > `BL_8 && ADDR[2:0] != `BL_FULL) ||
        (ADDR[6:4] != `CL_2 && ADDR[6:4] != `CL_3))) ||
        (flags_q[`FLAG_BADMODE_BIT] & ~(flag_wr & w_data_q[`FLAG_BADMODE_BIT]));
      // Load while a bank is open or a burst runs
      flags_q[`FLAG_BUSYLOAD_BIT] <= (cmd_lmr && (open_q != 4'h0 || bst_act_q)) ||
        (flags_q[`FLAG_BUSYLOAD_BIT] & ~(flag_wr & w_data_q[`FLAG_BUSYLOAD_BIT]));
    end
  end

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= `RESP_OKAY;
      case (S_AXI_ARADDR)
        `OFS_MODE: S_AXI_RDATA <= {20'h0, mode_q};
        `OFS_STATUS: S_AXI_RDATA <= {24'h0, bad_mode, drive_q, bst_act_q, self_q, open_q};
        `OFS_REFRESH: S_AXI_RDATA <= {3'h0, ref_row_q, ref_cnt_q};
        `OFS_CONTROL: S_AXI_RDATA <= {31'h0, ctrl_en_q};
        `OFS_FLAGS: S_AXI_RDATA <= {30'h0, flags_q};
        default: begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= `RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // sdram_cmd_decode
`default_nettype wire

// [verilog/sdram_cmd_regs.vh]
`ifndef SDRAM_CMD_REGS_VH
`define SDRAM_CMD_REGS_VH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_REFRESH 8'h08
`define OFS_CONTROL 8'h0c
`define OFS_FLAGS 8'h10

// Mode register fields
`define MODE_BL_LSB 0
`define MODE_BL_MSB 2
`define MODE_TYPE_BIT 3
`define MODE_CL_LSB 4
`define MODE_CL_MSB 6
`define MODE_OP_LSB 7
`define MODE_OP_MSB 8
`define MODE_WBM_BIT 9
`define MODE_RESET 12'h020

// Burst length and latency codes
`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_FULL 3'h7
`define CL_2 3'h2
`define CL_3 3'h3

// Address fields
`define AUTO_PRE_BIT 10

// Control and flags
`define CTRL_EN_BIT 0
`define CTRL_CLR_BIT 1
`define CTRL_RESET 1'h1
`define FLAG_BADMODE_BIT 0
`define FLAG_BUSYLOAD_BIT 1

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [verif/sdram_cmd_decode_props.sv]
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_chk (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Command bus
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [12:0] ADDR,
  input wire logic [7:0] BYTE_DATA_MASK,
  input wire logic [7:0] DQ_OE,
  // Register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  logic [11:0] mode_q;
  wire rd = !CS_N && RAS_N && !CAS_N && WE_N;
  wire lmr = !CS_N && !RAS_N && !CAS_N && !WE_N;
  wire lat3 = mode_q[6:4] == 3'h3;
  // Shadow of the last mode load, so latency and length are known here
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) mode_q <= 12'h020;
    else if (lmr) mode_q <= ADDR[11:0];
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  chk_rd_lat_two: assert property (
    rd && !lat3 && BYTE_DATA_MASK == 8'h00 |-> ##2 DQ_OE == 8'hff)
    else $error("latency two beat missing");
  chk_rd_lat_three: assert property (
    rd && lat3 && DQ_OE == 8'h00 ##1 BYTE_DATA_MASK == 8'h00 |->
    DQ_OE == 8'h00 ##1 DQ_OE == 8'h00 ##1 DQ_OE == 8'hff)
    else $error("latency three timing wrong");
  chk_mask_delay: assert property ((DQ_OE & $past(BYTE_DATA_MASK, 2)) == 8'h00)
    else $error("masked byte driven");
  chk_burst_four: assert property (
    rd && mode_q[2:0] == 3'h2 && !lat3 && DQ_OE == 8'h00 && BYTE_DATA_MASK == 8'h00
    |=> ##1 DQ_OE == 8'hff [*4] ##1 DQ_OE == 8'h00) else $error("burst of four length wrong");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write answer dropped");
  chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |=> ##1 S_AXI_BVALID) else $error("write answer late");
  cover property (rd && lat3);
  cover property (rd && mode_q[3]);
  cover property (lmr);
endmodule // sdram_cmd_chk
bind sdram_cmd_decode sdram_cmd_chk u_chk (.*);
`default_nettype wire

// [verif/host_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
module host_ctl (
  // Clock
  input wire logic REF_CLK,
  // Command bus
  output var logic CKE,
  output var logic CS_N,
  output var logic RAS_N,
  output var logic CAS_N,
  output var logic WE_N,
  output var logic [1:0] BA,
  output var logic [12:0] ADDR,
  output var logic [7:0] BYTE_DATA_MASK,
  // Write data
  output var logic [63:0] DQ_IN
);
  initial begin
    {CKE, CS_N, RAS_N, CAS_N, WE_N} = 5'h1f;
    BA = 2'h0;
    ADDR = 13'h0000;
    BYTE_DATA_MASK = 8'h00;
    DQ_IN = 64'h0;
  end
  task send(input [4:0] c, input [1:0] b, input [12:0] a, input [7:0] m, input [63:0] d);
    @(posedge REF_CLK);
    {CKE, CS_N, RAS_N, CAS_N, WE_N} <= c;
    BA <= b;
    ADDR <= a;
    BYTE_DATA_MASK <= m;
    DQ_IN <= d;
  endtask
  // Idle data flips, so stale write data never looks valid
  task nop;
    send(5'h17, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
  endtask
  task load(input [11:0] m);
    send(5'h12, 2'h0, 13'h0400, 8'h00, ~DQ_IN);
    send(5'h10, 2'h0, {3'h0, m[9], 2'h0, m[6:0]}, 8'h00, ~DQ_IN);
    nop;
    nop;
  endtask
endmodule // host_ctl
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic REF_CLK = 0;
  logic RSTN = 0;
  logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
  logic [31:0] S_AXI_WDATA = 0, v;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP, BA;
  wire [31:0] S_AXI_RDATA;
  wire CKE, CS_N, RAS_N, CAS_N, WE_N;
  wire [12:0] ADDR;
  wire [7:0] BYTE_DATA_MASK, DQ_OE;
  wire [63:0] DQ_IN, DQ_OUT;
  logic [63:0] mem [0:1023];
  logic [1:0] rsp;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  always #20 REF_CLK = ~REF_CLK;
  host_ctl host (.*);
  sdram_cmd_decode DUT (.*);
  task stop_test;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      stop_test;
    end
  end
  task axw(input [7:0] a, input [31:0] d, output [1:0] r);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1;
    S_AXI_WVALID <= 1;
    S_AXI_BREADY <= 1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 0;
    end while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 0;
  endtask
  task axr(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1;
    S_AXI_RREADY <= 1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
    end while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 0;
  endtask
  function automatic int col(int s, int k, int bl, bit il);
    int n;
    n = (bl == 7) ? 1024 : (1 << bl);
    return (s & ~(n - 1)) | (((il && n < 1024) ? (s ^ k) : (s + k)) & (n - 1));
  endfunction
  task rd_test(input [3:0] c, input int cl, input int st, input [7:0] m);
    int n, k;
    logic [7:0] eo;
    n = (c[2:0] == 3'h7) ? 8 : (1 << c[2:0]);
    host.load({5'h00, 3'(cl), c});
    host.send(5'h13, 2'h1, 13'h0123, 8'h00, ~DQ_IN);
    host.send(5'h15, 2'h1, 13'(st), m, ~DQ_IN);
    host.nop;
    repeat (cl - 2) @(posedge REF_CLK);
    for (k = 0; k < n; k++) begin
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      eo = (cl == 2 && k == 0) ? ~m : 8'hff;
      `CHK(DQ_OE, eo)
      if (eo == 8'hff) `CHK(DQ_OUT, mem[col(st, k, c[2:0], c[3])])
    end
    if (c[2:0] == 3'h7) host.send(5'h16, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
    host.nop;
    repeat (4) @(posedge REF_CLK);
  endtask
  initial begin
    int i, r, c;
    logic [63:0] d;
    logic [3:0] modes [0:7];
    modes = '{4'h8, 4'h1, 4'h9, 4'h2, 4'ha, 4'h3, 4'hb, 4'h7};
    void'($urandom(32'hdca59e70));
    repeat (10) @(posedge REF_CLK);
    RSTN <= 1;
    axr(8'h00, v, rsp);
    `CHK(v[11:0], 12'h020)
    axr(8'h40, v, rsp);
    `CHK(rsp, 2'h2)
    axw(8'h0c, 32'h1, rsp);
    `CHK(rsp, 2'h0)
    axw(8'h44, 32'h0, rsp);
    `CHK(rsp, 2'h2)
    $display("Register test done");
    host.load(12'h222);
    host.send(5'h13, 2'h1, 13'h0123, 8'h00, ~DQ_IN);
    // descending single writes expose any write burst
    for (i = 15; i >= 0; i--) begin
      c = (i < 8) ? i : 1008 + i;
      d = {$urandom, $urandom};
      mem[c] = d;
      host.send(5'h14, 2'h1, 13'(c), 8'h00, d);
    end
    d = {$urandom, $urandom};
    mem[3] = {d[63:8], mem[3][7:0]};
    // byte zero blocked on this write
    host.send(5'h14, 2'h1, 13'h0003, 8'h01, d);
    host.nop;
    axr(8'h04, v, rsp);
    `CHK(v[3:0], 4'h2)
    host.send(5'h12, 2'h1, 13'h0000, 8'h00, ~DQ_IN);
    axr(8'h04, v, rsp);
    `CHK(v[3:0], 4'h0)
    $display("Fill test done");
    for (i = 0; i < 8; i++) begin
      r = $urandom;
      rd_test(modes[i], 2 + r[8], (i == 7) ? 1020 + r % 4 : r % 8, i[0] ? r[23:16] : 8'h00);
    end
    $display("Burst test done");
    host.send(5'h1d, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
    repeat (4) begin
      @(negedge REF_CLK);
      `CHK(DQ_OE, 8'h00)
    end
    host.send(5'h11, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
    host.send(5'h11, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
    host.send(5'h01, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
    host.send(5'h0f, 2'h0, 13'h0000, 8'h00, ~DQ_IN);
    axr(8'h08, v, rsp);
    `CHK(v[15:0], 16'h0002)
    axr(8'h04, v, rsp);
    `CHK(v[4], 1'b1)
    host.nop;
    axr(8'h04, v, rsp);
    `CHK(v[4], 1'b0)
    $display("Refresh test done");
    stop_test;
  end
endmodule // tb
`default_nettype wire
